// *** design/flash_host_pkg.sv ***
// Contract
// - host waits the recovery time after reset release before reading.
// - host reissues any program or erase cut off by hardware reset; the controller does not reissue, the user must.
// - word program needs the three-cycle unlock prefix first.
// - erase needs the complete six-cycle command sequence.
// - upper data lines are ignored in commands but host drives them valid.
// - query mode entry is the prefix ending with 98H at 555H.
// - host issues the exit command to leave query mode.
// - host programs user security half with its command, polls toggle bits only; the code does not poll, DONE_OUT follows the last write.
// - security mode entry is prefix ending with 88H at 555H, left by exit command.
package flash_host_pkg;
  localparam int CLK_MHZ = 25;
  localparam int PULSE_NS = 80;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_PULSE_MIN_NS = 500;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_RECOVERY_TIME_NS = 50;
  localparam int RECOVERY_CYC = (RESET_RECOVERY_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [10:0] ADDR_UNLOCK1 = 11'h555;
  localparam logic [10:0] ADDR_UNLOCK2 = 11'h2aa;
  localparam logic [7:0] DATA_UNLOCK1 = 8'haa;
  localparam logic [7:0] DATA_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h50;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h30;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SEC_PROGRAM = 8'ha5;
  localparam logic [7:0] CMD_SEC_LOCK = 8'h85;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_QUERY_ENTRY = 8'h98;
  localparam logic [7:0] CMD_SEC_ENTRY = 8'h88;
  localparam logic [7:0] CMD_EXIT = 8'hf0;
  localparam logic [21:0] TOP_BLOCK_BASE = 22'h3f8000;
  localparam logic [21:0] BOTTOM_BLOCK_END = 22'h007fff;
  localparam logic [21:0] ADDR_MAKER = 22'h000000;
  localparam logic [21:0] ADDR_DEVICE = 22'h000001;
  localparam logic [21:0] ADDR_USER_SEC = 22'h000010;
  localparam logic [21:0] ADDR_LOCK = 22'h0000ff;
  localparam int LOCK_STATE_BIT = 3;
  localparam logic [15:0] SEC_LOCK_DATA = 16'h0000;
  // operation codes on the user port
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_PROGRAM = 4'h1;
  localparam logic [3:0] OP_SECTOR_ERASE = 4'h2;
  localparam logic [3:0] OP_BLOCK_ERASE = 4'h3;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h4;
  localparam logic [3:0] OP_ID_ENTRY = 4'h5;
  localparam logic [3:0] OP_QUERY_ENTRY = 4'h6;
  localparam logic [3:0] OP_SEC_ENTRY = 4'h7;
  localparam logic [3:0] OP_EXIT = 4'h8;
  localparam logic [3:0] OP_SEC_PROGRAM = 4'h9;
  localparam logic [3:0] OP_SEC_LOCK = 4'ha;
  localparam logic [3:0] OP_HW_RESET = 4'hb;
  localparam logic [3:0] OP_SHORT_EXIT = 4'hc;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_HOLD = 3'b011,
    ST_RST_LOW = 3'b100,
    ST_RST_REC = 3'b101
  } state_t;
endpackage : flash_host_pkg

// *** design/flash_host_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_host_ctrl (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic REQ_IN,
  input wire logic [3:0] OP_IN,
  input wire logic [21:0] ADDR_IN,
  input wire logic [15:0] DATA_IN,
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic [15:0] RDATA_OUT,
  output logic [21:0] FLASH_ADDR_OUT,
  output logic [15:0] FLASH_DQ_OUT,
  output logic FLASH_DQ_OE_OUT,
  input wire logic [15:0] FLASH_DQ_IN,
  output logic FLASH_CE_N_OUT,
  output logic FLASH_OE_N_OUT,
  output logic FLASH_WE_N_OUT,
  output logic FLASH_RST_N_OUT
);
  flash_host_pkg::state_t state_q;
  logic [2:0] cyc_q;
  logic [2:0] last_q;
  logic [7:0] cnt_q;
  logic [3:0] op_q;
  logic [21:0] addr_q;
  logic [15:0] data_q;
  logic rd_q;

  // one bus write of the sequence: address and 16-bit data word
  function automatic logic [37:0] seq_word(input logic [3:0] op, input logic [2:0] idx,
                                           input logic [21:0] a, input logic [15:0] d);
    logic [7:0] cmd;
    logic erase;
    cmd = 8'h00;
    erase = (op == flash_host_pkg::OP_SECTOR_ERASE) || (op == flash_host_pkg::OP_BLOCK_ERASE) ||
            (op == flash_host_pkg::OP_CHIP_ERASE);
    unique case (op)
      flash_host_pkg::OP_PROGRAM: cmd = flash_host_pkg::CMD_PROGRAM;
      flash_host_pkg::OP_SEC_PROGRAM: cmd = flash_host_pkg::CMD_SEC_PROGRAM;
      flash_host_pkg::OP_SEC_LOCK: cmd = flash_host_pkg::CMD_SEC_LOCK;
      flash_host_pkg::OP_ID_ENTRY: cmd = flash_host_pkg::CMD_ID_ENTRY;
      flash_host_pkg::OP_QUERY_ENTRY: cmd = flash_host_pkg::CMD_QUERY_ENTRY;
      flash_host_pkg::OP_SEC_ENTRY: cmd = flash_host_pkg::CMD_SEC_ENTRY;
      flash_host_pkg::OP_EXIT: cmd = flash_host_pkg::CMD_EXIT;
      default: cmd = flash_host_pkg::CMD_ERASE_SETUP;
    endcase
    if (op == flash_host_pkg::OP_SHORT_EXIT || op == flash_host_pkg::OP_READ) begin
      // reads and the one-cycle exit go straight to the target
      seq_word = {a, 8'h00, flash_host_pkg::CMD_EXIT};
    end else begin
      // prefix cycles, upper byte driven low
      unique case (idx)
        3'd0: seq_word = {11'h000, flash_host_pkg::ADDR_UNLOCK1, 8'h00, flash_host_pkg::DATA_UNLOCK1};
        3'd1, 3'd4: seq_word = {11'h000, flash_host_pkg::ADDR_UNLOCK2, 8'h00, flash_host_pkg::DATA_UNLOCK2};
        3'd2: seq_word = {11'h000, flash_host_pkg::ADDR_UNLOCK1, 8'h00, cmd};
        3'd3: begin
          // fourth write: second prefix for erase, payload otherwise
          if (erase) begin
            seq_word = {11'h000, flash_host_pkg::ADDR_UNLOCK1, 8'h00, flash_host_pkg::DATA_UNLOCK1};
          end else if (op == flash_host_pkg::OP_SEC_LOCK) begin
            seq_word = {a, flash_host_pkg::SEC_LOCK_DATA};
          end else begin
            seq_word = {a, d};
          end
        end
        default: begin
          if (op == flash_host_pkg::OP_SECTOR_ERASE) begin
            seq_word = {a, 8'h00, flash_host_pkg::CMD_SECTOR_ERASE};
          end else if (op == flash_host_pkg::OP_BLOCK_ERASE) begin
            seq_word = {a, 8'h00, flash_host_pkg::CMD_BLOCK_ERASE};
          end else begin
            seq_word = {11'h000, flash_host_pkg::ADDR_UNLOCK1, 8'h00, flash_host_pkg::CMD_CHIP_ERASE};
          end
        end
      endcase
    end
  endfunction : seq_word

  // number of bus cycles minus one for an operation
  function automatic logic [2:0] seq_last(input logic [3:0] op);
    unique case (op)
      flash_host_pkg::OP_READ, flash_host_pkg::OP_SHORT_EXIT: seq_last = 3'd0;
      // program, security program, lock-out: prefix plus data
      flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_SEC_PROGRAM,
      flash_host_pkg::OP_SEC_LOCK: seq_last = 3'd3;
      // erase is always the full six writes
      flash_host_pkg::OP_SECTOR_ERASE, flash_host_pkg::OP_BLOCK_ERASE,
      flash_host_pkg::OP_CHIP_ERASE: seq_last = 3'd5;
      default: seq_last = 3'd2;
    endcase
  endfunction : seq_last

  logic [37:0] word_d;
  assign word_d = seq_word(op_q, cyc_q, addr_q, data_q);

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_q <= flash_host_pkg::ST_IDLE;
      cyc_q <= 3'd0;
      last_q <= 3'd0;
      cnt_q <= 8'h00;
      op_q <= 4'h0;
      addr_q <= 22'h000000;
      data_q <= 16'h0000;
      rd_q <= 1'b0;
    end else begin
      unique case (state_q)
        flash_host_pkg::ST_IDLE: begin
          // pin high a cycle first, else select follows reset too soon
          if (REQ_IN && FLASH_RST_N_OUT) begin
            op_q <= OP_IN;
            addr_q <= ADDR_IN;
            data_q <= DATA_IN;
            cyc_q <= 3'd0;
            last_q <= seq_last(OP_IN);
            rd_q <= (OP_IN == flash_host_pkg::OP_READ);
            cnt_q <= 8'h00;
            // hold reset pin low for the minimum pulse
            state_q <= (OP_IN == flash_host_pkg::OP_HW_RESET) ? flash_host_pkg::ST_RST_LOW
                                                               : flash_host_pkg::ST_SETUP;
          end
        end
        flash_host_pkg::ST_SETUP: begin
          state_q <= flash_host_pkg::ST_STROBE;
          cnt_q <= 8'h00;
        end
        flash_host_pkg::ST_STROBE: begin
          // strobe kept far above the glitch width
          if (cnt_q == 8'(flash_host_pkg::PULSE_CYC - 1)) begin
            state_q <= flash_host_pkg::ST_HOLD;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        flash_host_pkg::ST_HOLD: begin
          if (cyc_q == last_q) begin
            state_q <= flash_host_pkg::ST_IDLE;
          end else begin
            cyc_q <= cyc_q + 3'd1;
            state_q <= flash_host_pkg::ST_SETUP;
          end
        end
        flash_host_pkg::ST_RST_LOW: begin
          if (cnt_q == 8'(flash_host_pkg::RESET_PULSE_CYC - 1)) begin
            cnt_q <= 8'h00;
            state_q <= flash_host_pkg::ST_RST_REC;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        flash_host_pkg::ST_RST_REC: begin
          // recovery wait; user reissues cut work
          if (cnt_q == 8'(flash_host_pkg::RECOVERY_CYC - 1)) begin
            state_q <= flash_host_pkg::ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        default: state_q <= flash_host_pkg::ST_IDLE;
      endcase
    end
  end

  // pin drive; write only with select low, output enable high
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      FLASH_ADDR_OUT <= 22'h000000;
      FLASH_DQ_OUT <= 16'h0000;
      FLASH_DQ_OE_OUT <= 1'b0;
      FLASH_CE_N_OUT <= 1'b1;
      FLASH_OE_N_OUT <= 1'b1;
      FLASH_WE_N_OUT <= 1'b1;
      FLASH_RST_N_OUT <= 1'b0;
    end else begin
      FLASH_RST_N_OUT <= (state_q != flash_host_pkg::ST_RST_LOW);
      FLASH_ADDR_OUT <= word_d[37:16];
      FLASH_DQ_OUT <= word_d[15:0];
      FLASH_DQ_OE_OUT <= !rd_q && (state_q == flash_host_pkg::ST_SETUP || state_q == flash_host_pkg::ST_STROBE);
      FLASH_CE_N_OUT <= !(state_q == flash_host_pkg::ST_SETUP || state_q == flash_host_pkg::ST_STROBE);
      FLASH_OE_N_OUT <= !(rd_q && state_q == flash_host_pkg::ST_STROBE);
      FLASH_WE_N_OUT <= !(!rd_q && state_q == flash_host_pkg::ST_STROBE);
    end
  end

  // user answer; data sampled at the end of the read strobe
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      BUSY_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      RDATA_OUT <= 16'h0000;
    end else begin
      BUSY_OUT <= (state_q != flash_host_pkg::ST_IDLE) || (REQ_IN && FLASH_RST_N_OUT);
      DONE_OUT <= (state_q == flash_host_pkg::ST_HOLD && cyc_q == last_q) ||
                  (state_q == flash_host_pkg::ST_RST_REC && cnt_q == 8'(flash_host_pkg::RECOVERY_CYC - 1));
      if (rd_q && state_q == flash_host_pkg::ST_HOLD) begin
        RDATA_OUT <= FLASH_DQ_IN;
      end
    end
  end

  // write strobe is at least the pulse length
  a_we_width: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    $fell(FLASH_WE_N_OUT) |-> !FLASH_WE_N_OUT [*2]) else $error("write strobe too short");
  // write strobe never with output enable low
  a_write_inhibit: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    !FLASH_WE_N_OUT |-> FLASH_OE_N_OUT && !FLASH_CE_N_OUT && FLASH_DQ_OE_OUT) else $error("write with inhibit");
  a_reset_pulse: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    $fell(FLASH_RST_N_OUT) |-> !FLASH_RST_N_OUT [*8]) else $error("reset pulse short");
  a_reset_recov: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    $rose(FLASH_RST_N_OUT) |-> FLASH_CE_N_OUT [*2]) else $error("access during recovery");
  sequence s_prefix1;
    FLASH_ADDR_OUT[10:0] == flash_host_pkg::ADDR_UNLOCK1 && FLASH_DQ_OUT[7:0] == flash_host_pkg::DATA_UNLOCK1;
  endsequence
  // program begins with the unlock word
  a_prog_prefix: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    $fell(FLASH_WE_N_OUT) && state_q == flash_host_pkg::ST_STROBE && cyc_q == 3'd0 && op_q != flash_host_pkg::OP_SHORT_EXIT
    |-> s_prefix1) else $error("missing unlock prefix");
  a_erase_six: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    state_q == flash_host_pkg::ST_HOLD && cyc_q == last_q && op_q == flash_host_pkg::OP_CHIP_ERASE
    |-> cyc_q == 3'd5 && FLASH_ADDR_OUT[10:0] == flash_host_pkg::ADDR_UNLOCK1 &&
    FLASH_DQ_OUT[7:0] == flash_host_pkg::CMD_CHIP_ERASE) else $error("short erase sequence");
  // fourth program write carries target and data
  a_prog_data: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    !FLASH_WE_N_OUT && cyc_q == 3'd3 && op_q == flash_host_pkg::OP_PROGRAM
    |-> FLASH_ADDR_OUT == addr_q && FLASH_DQ_OUT == data_q) else $error("bad program data cycle");
  // upper data lines held low in the first three writes; checked for every operation but program
  a_upper_low: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    !FLASH_WE_N_OUT && cyc_q < 3'd3 && op_q != flash_host_pkg::OP_PROGRAM |-> FLASH_DQ_OUT[15:8] == 8'h00)
    else $error("upper lines not driven low");
  a_prefix_two: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    !FLASH_WE_N_OUT && cyc_q == 3'd1 |-> FLASH_ADDR_OUT[10:0] == flash_host_pkg::ADDR_UNLOCK2) else $error("bad second cycle");
endmodule : flash_host_ctrl
`default_nettype wire

// *** tb/flash_dev_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
  parameter bit TOP_GUARD = 1'b0,
  // arbitrary codes, not those of any real part
  parameter logic [15:0] MAKER_CODE = 16'h00c3,
  parameter logic [15:0] PART_CODE = 16'h4a21,
  parameter logic [15:0] FACTORY_SEED = 16'h6b17
) (
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic rst_n_in,
  input wire logic wp_n_in,
  input wire logic [21:0] addr_in,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out
);
  logic [15:0] mem [int];
  logic [15:0] user_sec [8] = '{default: 16'hffff};
  logic [15:0] rd = 16'h0000;
  logic [15:0] wd;
  logic [21:0] wa;
  logic [7:0] cmd = 8'h00;
  logic locked = 1'b0;
  int step = 0;
  int mode = 0;
  realtime t_we = 0.0;
  realtime t_rst = 0.0;
  wire logic wr_act = !ce_n_in && !we_n_in && oe_n_in && rst_n_in;
  function automatic bit guarded(input logic [21:0] a);
    return !wp_n_in && (TOP_GUARD ? a >= 22'h3f8000 : a <= 22'h007fff);
  endfunction : guarded
  function automatic logic [15:0] fetch(input logic [21:0] a);
    case (mode)
      1: return a == 22'h0 ? MAKER_CODE : (a == 22'h1 ? PART_CODE : 16'hffff);
      2: return {8'h51, a[7:0]};
      3: begin
        if (a == 22'h0000ff) return {12'h000, !locked, 3'b000};
        if (a[21:5] == 17'h0 && !a[3]) return a[4] ? user_sec[a[2:0]] : FACTORY_SEED ^ {13'h0000, a[2:0]};
        return 16'hffff;
      end
      default: return mem.exists(a) ? mem[a] : 16'hffff;
    endcase
  endfunction : fetch
  task automatic take(input logic [21:0] a, input logic [15:0] d);
    logic hit;
    hit = (step == 1 || step == 5) ? (a[10:0] == 11'h2aa && d[7:0] == 8'h55) : (a[10:0] == 11'h555 && d[7:0] == 8'haa);
    case (step)
      0: begin
        if (hit) step = 1;
        // writes finish at once, so exit never meets a busy array
        else if (d[7:0] == 8'hf0) mode = 0;
      end
      1, 4, 5: begin
        step = hit ? step + 1 : 0;
        if (!hit) mode = 0;
      end
      2: begin
        step = 0;
        cmd = d[7:0];
        if (a[10:0] != 11'h555) mode = 0;
        else case (cmd)
          8'ha0, 8'ha5, 8'h85: step = 3;
          8'h80: step = 4;
          8'h90: mode = 1;
          8'h98: mode = 2;
          8'h88: mode = 3;
          default: mode = 0;
        endcase
      end
      3: begin
        step = 0;
        if (cmd == 8'ha0 && !guarded(a)) mem[a] = (mem.exists(a) ? mem[a] : 16'hffff) & d;
        if (cmd == 8'ha5 && !locked && a[21:3] == 19'h2) user_sec[a[2:0]] = user_sec[a[2:0]] & d;
        if (cmd == 8'h85) locked = 1'b1;
      end
      6: begin
        step = 0;
        foreach (mem[k]) begin
          if ((d[7:0] == 8'h50 && k[21:11] == a[21:11] && !guarded(a)) ||
              (d[7:0] == 8'h30 && k[21:15] == a[21:15] && !guarded(a)) ||
              (d[7:0] == 8'h10 && wp_n_in)) mem[k] = 16'hffff;
        end
      end
      default: step = 0;
    endcase
  endtask : take
  // glitch filter and write inhibit; first rising strobe ends the write
  always @(posedge wr_act) begin
    t_we = $realtime;
    wa = addr_in;
    wd = dq_in;
  end
  always @(negedge wr_act) begin
    if ($realtime - t_we >= 5.0) take(wa, wd);
  end
  // long reset pulse back to array read
  always @(rst_n_in) begin
    if (!rst_n_in) t_rst = $realtime;
    else if ($realtime - t_rst >= 500.0) begin
      step = 0;
      mode = 0;
    end
  end
  always @(negedge oe_n_in) rd = fetch(addr_in);
  // released bus shows the inverse, so a stale capture cannot pass
  assign dq_out = (!ce_n_in && !oe_n_in) ? rd : ~rd;
endmodule : flash_dev_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic wp_n = 1'b1;
  logic [3:0] op = 4'h0;
  logic [21:0] addr = 22'h000000;
  logic [21:0] f_addr, ra;
  logic [15:0] data = 16'h0000;
  logic [15:0] rdata, dq_o, dq_wire, dev_dq, v1, v2;
  logic busy, done, dq_oe, ce_n, oe_n, we_n, rst_n;
  logic [16:0] notes [$];
  logic [16:0] note;
  int errors = 0;
  int check_count = 0;
  always #20 clk = ~clk;
  assign dq_wire = dq_oe ? dq_o : dev_dq;
  flash_host_ctrl i_dut (
    .CLK_IN(clk), .RESET_IN(rst), .REQ_IN(req), .OP_IN(op), .ADDR_IN(addr), .DATA_IN(data),
    .BUSY_OUT(busy), .DONE_OUT(done), .RDATA_OUT(rdata), .FLASH_ADDR_OUT(f_addr), .FLASH_DQ_OUT(dq_o),
    .FLASH_DQ_OE_OUT(dq_oe), .FLASH_DQ_IN(dq_wire), .FLASH_CE_N_OUT(ce_n), .FLASH_OE_N_OUT(oe_n),
    .FLASH_WE_N_OUT(we_n), .FLASH_RST_N_OUT(rst_n)
  );
  flash_dev_model i_dev (
    .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .rst_n_in(rst_n), .wp_n_in(wp_n),
    .addr_in(f_addr), .dq_in(dq_wire), .dq_out(dev_dq)
  );
  task automatic close_out();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic run(input logic [3:0] o, input logic [21:0] a, input logic [15:0] d, input logic c,
                     input logic [15:0] e);
    int n;
    notes.push_back({c, e});
    @(posedge clk);
    #2 req = 1'b1;
    op = o;
    addr = a;
    data = d;
    @(posedge clk);
    #2 req = 1'b0;
    `CHK(busy, 1'b1)
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) errors++;
  endtask : run
  task automatic rd(input logic [21:0] a, input logic [15:0] e);
    run(flash_host_pkg::OP_READ, a, 16'h0000, 1'b1, e);
  endtask : rd
  task automatic go(input logic [3:0] o, input logic [21:0] a, input logic [15:0] d);
    run(o, a, d, 1'b0, 16'h0000);
  endtask : go
  task automatic set_wp(input logic v);
    @(posedge clk);
    #2 wp_n = v;
  endtask : set_wp
  // results are matched in completion order
  always @(negedge clk) begin
    if (done === 1'b1) begin
      if (notes.size() == 0) errors++;
      else begin
        note = notes.pop_front();
        if (note[16]) `CHK(rdata, note[15:0])
      end
    end
  end
  initial begin
    #(40 * 6000);
    errors++;
    close_out();
  end
  initial begin
    void'($urandom(32'h304559e5));
    ra = {1'b1, 21'($urandom)};
    v1 = 16'($urandom);
    v2 = 16'($urandom);
    repeat (3) @(posedge clk);
    #2 rst = 1'b0;
    rd(ra, 16'hffff);
    go(flash_host_pkg::OP_PROGRAM, ra, v1);
    rd(ra, v1);
    set_wp(1'b0);
    go(flash_host_pkg::OP_PROGRAM, 22'h000100, v1);
    rd(22'h000100, 16'hffff);
    set_wp(1'b1);
    go(flash_host_pkg::OP_PROGRAM, 22'h007fff, v2);
    rd(22'h007fff, v2);
    set_wp(1'b0);
    go(flash_host_pkg::OP_SECTOR_ERASE, 22'h007fff, 16'h0000);
    go(flash_host_pkg::OP_CHIP_ERASE, 22'h000000, 16'h0000);
    rd(22'h007fff, v2);
    for (int i = 0; i < 3; i++) begin
      go(flash_host_pkg::OP_PROGRAM, ra, v1);
      go(4'(flash_host_pkg::OP_SECTOR_ERASE + i), ra, 16'h0000);
      rd(ra, (i == 2) ? v1 : 16'hffff);
    end
    set_wp(1'b1);
    go(flash_host_pkg::OP_ID_ENTRY, 22'h000000, 16'h0000);
    rd(22'h000000, 16'h00c3);
    rd(22'h000001, 16'h4a21);
    go(flash_host_pkg::OP_EXIT, 22'h000000, 16'h0000);
    rd(22'h007fff, v2);
    go(flash_host_pkg::OP_QUERY_ENTRY, 22'h000000, 16'h0000);
    rd(22'h000010, 16'h5110);
    go(flash_host_pkg::OP_SHORT_EXIT, 22'h000000, 16'h0000);
    rd(22'h007fff, v2);
    go(flash_host_pkg::OP_SEC_ENTRY, 22'h000000, 16'h0000);
    rd(22'h0000ff, 16'h0008);
    go(flash_host_pkg::OP_SEC_PROGRAM, 22'h000010, v1);
    rd(22'h000010, v1);
    rd(22'h000003, 16'h6b14);
    go(flash_host_pkg::OP_SEC_LOCK, 22'h000000, 16'h0000);
    go(flash_host_pkg::OP_SEC_PROGRAM, 22'h000011, 16'h0000);
    rd(22'h000011, 16'hffff);
    rd(22'h0000ff, 16'h0000);
    go(flash_host_pkg::OP_CHIP_ERASE, 22'h000000, 16'h0000);
    rd(22'h000010, v1);
    go(flash_host_pkg::OP_EXIT, 22'h000000, 16'h0000);
    rd(22'h007fff, 16'hffff);
    go(flash_host_pkg::OP_ID_ENTRY, 22'h000000, 16'h0000);
    go(flash_host_pkg::OP_HW_RESET, 22'h000000, 16'h0000);
    rd(22'h000000, 16'hffff);
    go(flash_host_pkg::OP_PROGRAM, ra, v2);
    rd(ra, v2);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
